// [hw/svo_regs.sv]
// System undervoltage protection byte and source-mode output voltage register
// ----------------------------------------------------------------
// Summary of operation
// - Threshold code in bits 7:2, 100 mV steps
// - Reset threshold from cell-count strap
// - Follow flag selects first threshold instead
// - Bit 0 enables fast swap, resets off
// - Enable rise turns power stage off 200 us
// - High impedance forces fast swap bit zero
// - Setpoint code in bits 13:2, 8 mV steps
// - Setpoint clamped between 3 V and 24 V
// - Out-of-range setpoint writes are ignored
// - Bits 15:14 zero; writing one is invalid
// - Setpoint register resets to 0x09C4
// - Threshold adds 3.2 V; flag rail below
// - Rail comparison deglitched for 5 us
// - Single cell saturates threshold at 3.9 V
// ----------------------------------------------------------------
`timescale 1ns/1ns
module svo_regs #(
  parameter int FRS_OFF_CYCLES = svo_pkg::FRS_OFF_CYC,
  parameter int DEGLITCH_CYCLES = svo_pkg::DEGLITCH_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire svo_pkg::svo_req_s reg_req,
  output logic [7:0] reg_rdata_q,
  input wire logic multi_cell,
  input wire logic high_impedance_enable,
  input wire logic [5:0] sys_rail_first_threshold,
  input wire logic [15:0] sys_rail_mv,
  output logic [15:0] sys_rail_second_threshold_mv_q,
  output logic sys_rail_low_flag_q,
  output logic fast_swap_enable_q,
  output logic power_stage_off_q,
  output logic [15:0] source_setpoint_mv_q
);

  svo_pkg::svo_state_s s_q;
  svo_pkg::svo_state_s s_d;

  logic [15:0] vout_cand;
  logic [11:0] vout_code;
  logic [11:0] vout_eff;
  logic [5:0] th_code;
  logic rail_below;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    vout_cand = s_q.vout;
    vout_code = '0;
    vout_eff = '0;
    th_code = '0;

    // Strap is caught on the first edge after reset release
    if (!s_q.strap_done)
    begin
      s_d.strap_done = 1'b1;
      if (multi_cell)
      begin
        s_d.prot = s_q.prot | svo_pkg::PROT_MULTI_BITS;
      end
    end

    // Register writes
    if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        svo_pkg::ADDR_PROT_LO:
        begin
          s_d.prot = reg_req.wdata;
        end
        svo_pkg::ADDR_VOUT_LO:
        begin
          vout_cand = {s_q.vout[15:8], reg_req.wdata};
        end
        svo_pkg::ADDR_VOUT_HI:
        begin
          vout_cand = {reg_req.wdata, s_q.vout[7:0]};
        end
        default:
        begin
          vout_cand = s_q.vout;
        end
      endcase
    end
    // Low two bits carry no value and always read zero
    vout_cand[1:0] = 2'h0;
    vout_code = vout_cand[13:svo_pkg::VOUT_LSB_BIT];
    // Judge the whole 16-bit candidate so a byte write never half-applies
    if (vout_cand[15:14] == 2'h0
        && vout_code >= svo_pkg::VOUT_MIN_CODE
        && vout_code <= svo_pkg::VOUT_MAX_CODE)
    begin
      s_d.vout = vout_cand;
    end

    // High impedance wins over fast swap
    if (high_impedance_enable)
    begin
      s_d.prot[svo_pkg::FRS_BIT] = 1'b0;
    end

    // Power stage blanking on enable rise
    if (s_d.prot[svo_pkg::FRS_BIT] && !s_q.prot[svo_pkg::FRS_BIT])
    begin
      s_d.stage_off = 1'b1;
      s_d.frs_cnt = '0;
    end
    else if (s_q.stage_off)
    begin
      if (s_q.frs_cnt == svo_pkg::CNT_W'(FRS_OFF_CYCLES - 1))
      begin
        s_d.stage_off = 1'b0;
      end
      else
      begin
        s_d.frs_cnt = s_q.frs_cnt + svo_pkg::CNT_W'(1);
      end
    end

    // Effective undervoltage threshold
    if (s_d.prot[svo_pkg::FOLLOW_BIT])
    begin
      th_code = sys_rail_first_threshold;
    end
    else
    begin
      th_code = s_d.prot[7:svo_pkg::TH_LSB_BIT];
    end
    if (!multi_cell && th_code > svo_pkg::TH_1S_MAX_CODE)
    begin
      th_code = svo_pkg::TH_1S_MAX_CODE;
    end
    s_d.thresh_mv = 16'(svo_pkg::TH_OFFSET_MV)
      + 16'(th_code) * 16'(svo_pkg::TH_LSB_MV);

    // Clamp kept as a guard even though stored codes are already in range
    vout_eff = s_d.vout[13:svo_pkg::VOUT_LSB_BIT];
    if (vout_eff < svo_pkg::VOUT_MIN_CODE)
    begin
      vout_eff = svo_pkg::VOUT_MIN_CODE;
    end
    else if (vout_eff > svo_pkg::VOUT_MAX_CODE)
    begin
      vout_eff = svo_pkg::VOUT_MAX_CODE;
    end
    s_d.setpoint_mv = 16'(vout_eff) * 16'(svo_pkg::VOUT_LSB_MV);

    // Read data, one cycle after the strobe
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        svo_pkg::ADDR_PROT_LO:
        begin
          s_d.rdata = s_q.prot;
        end
        svo_pkg::ADDR_VOUT_LO:
        begin
          s_d.rdata = s_q.vout[7:0];
        end
        svo_pkg::ADDR_VOUT_HI:
        begin
          s_d.rdata = s_q.vout[15:8];
        end
        default:
        begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q.prot <= svo_pkg::PROT_RST_1S;
      s_q.vout <= svo_pkg::VOUT_RST;
      s_q.strap_done <= 1'b0;
      s_q.frs_cnt <= '0;
      s_q.stage_off <= 1'b0;
      s_q.rdata <= svo_pkg::RDATA_RST;
      s_q.thresh_mv <= 16'(svo_pkg::TH_OFFSET_MV + svo_pkg::TH_LSB_MV);
      s_q.setpoint_mv <= 16'(32'(svo_pkg::VOUT_RST[13:2]) * svo_pkg::VOUT_LSB_MV);
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Rail comparison and deglitch
  // ----------------------------------------------------------------
  assign rail_below = sys_rail_mv < s_q.thresh_mv;

  svo_deglitch #(
    .CYCLES(DEGLITCH_CYCLES)
  ) u_deglitch (
    .clk(clk),
    .rst_b(rst_b),
    .raw(rail_below),
    .filt_q(sys_rail_low_flag_q)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_q = s_q.rdata;
  assign sys_rail_second_threshold_mv_q = s_q.thresh_mv;
  assign fast_swap_enable_q = s_q.prot[svo_pkg::FRS_BIT];
  assign power_stage_off_q = s_q.stage_off;
  assign source_setpoint_mv_q = s_q.setpoint_mv;

endmodule

// [hw/svo_pkg.sv]
// Package: register map, reset values, timing constants and state structs
package svo_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_VOUT_LO = 8'h06;
  localparam logic [7:0] ADDR_VOUT_HI = 8'h07;
  localparam logic [7:0] ADDR_PROT_LO = 8'h3E;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int FRS_BIT = 0;
  localparam int FOLLOW_BIT = 1;
  localparam int TH_LSB_BIT = 2;
  localparam int VOUT_LSB_BIT = 2;
  localparam logic [7:0] PROT_RST_1S = 8'h04;
  localparam logic [7:0] PROT_MULTI_BITS = 8'h68;
  localparam logic [15:0] VOUT_RST = 16'h09C4;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // Scaling
  // ----------------------------------------------------------------
  localparam int TH_OFFSET_MV = 3200;
  localparam int TH_LSB_MV = 100;
  localparam logic [5:0] TH_1S_MAX_CODE = 6'h07;
  localparam int VOUT_LSB_MV = 8;
  localparam int VOUT_MIN_MV = 3000;
  localparam int VOUT_MAX_MV = 24000;
  localparam logic [11:0] VOUT_MIN_CODE = 12'(VOUT_MIN_MV / VOUT_LSB_MV);
  localparam logic [11:0] VOUT_MAX_CODE = 12'(VOUT_MAX_MV / VOUT_LSB_MV);

  // ----------------------------------------------------------------
  // Timing at 100 MHz
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int DEGLITCH_US = 5;
  localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
  localparam int FRS_OFF_US = 200;
  localparam int FRS_OFF_CYC = FRS_OFF_US * CLK_MHZ;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } svo_req_s;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic filt;
  } svo_filt_s;

  typedef struct packed {
    logic [7:0] prot;
    logic [15:0] vout;
    logic strap_done;
    logic [CNT_W-1:0] frs_cnt;
    logic stage_off;
    logic [7:0] rdata;
    logic [15:0] thresh_mv;
    logic [15:0] setpoint_mv;
  } svo_state_s;

endpackage

// [hw/svo_deglitch.sv]
// Deglitch filter: output rises only after the input held high for CYCLES clocks
`timescale 1ns/1ns
module svo_deglitch #(
  parameter int CYCLES = svo_pkg::DEGLITCH_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic raw,
  output logic filt_q
);

  svo_pkg::svo_filt_s s_q;
  svo_pkg::svo_filt_s s_d;

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  // Release is immediate so a recovered rail is reported without delay
  always_comb
  begin
    s_d = s_q;
    if (!raw)
    begin
      s_d.cnt = '0;
      s_d.filt = 1'b0;
    end
    else if (s_q.cnt == svo_pkg::CNT_W'(CYCLES - 1))
    begin
      s_d.filt = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + svo_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign filt_q = s_q.filt;

endmodule

// [hw/_end_unused.sv]
// Holds no logic

// [dv/svo_regs_monitor.sv]
// Checker for the undervolt threshold and source setpoint outputs
`timescale 1ns/1ns
module svo_regs_monitor #(
  parameter int FRS_OFF_CYCLES = 20,
  parameter int DEGLITCH_CYCLES = 5
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire svo_pkg::svo_req_s reg_req,
  input wire logic [7:0] reg_rdata_q,
  input wire logic multi_cell,
  input wire logic high_impedance_enable,
  input wire logic [5:0] sys_rail_first_threshold,
  input wire logic [15:0] sys_rail_mv,
  input wire logic [15:0] sys_rail_second_threshold_mv_q,
  input wire logic sys_rail_low_flag_q,
  input wire logic fast_swap_enable_q,
  input wire logic power_stage_off_q,
  input wire logic [15:0] source_setpoint_mv_q
);
  // ----------------------------------------------------------------
  // Run-length counters; repetition cannot reach these lengths
  // ----------------------------------------------------------------
  logic below;
  logic [15:0] below_q;
  logic [15:0] off_q;
  assign below = sys_rail_mv < sys_rail_second_threshold_mv_q;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      below_q <= 16'h0000;
      off_q <= 16'h0000;
    end
    else
    begin
      below_q <= below ? below_q + 16'h0001 : 16'h0000;
      off_q <= power_stage_off_q ? off_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_swap_rise; $rose(fast_swap_enable_q); endsequence
  sequence s_stage_end; $fell(power_stage_off_q); endsequence
  property p_hiz; high_impedance_enable |=> !fast_swap_enable_q; endproperty
  property p_off; s_swap_rise |-> power_stage_off_q; endproperty
  property p_off_len; s_stage_end |-> off_q == 16'(FRS_OFF_CYCLES); endproperty
  property p_sp_rng; source_setpoint_mv_q >= 16'h0BB8 && source_setpoint_mv_q <= 16'h5DC0;
  endproperty
  property p_sp_step; source_setpoint_mv_q[2:0] == 3'h0; endproperty
  property p_th_cap; !multi_cell [*2] |-> sys_rail_second_threshold_mv_q <= 16'h0F3C;
  endproperty
  property p_low_fall; !below |=> !sys_rail_low_flag_q; endproperty
  // Flag rises exactly when the run of below samples reaches the filter length
  property p_dg; $rose(sys_rail_low_flag_q) |-> below_q == 16'(DEGLITCH_CYCLES); endproperty
  a_hiz: assert property (p_hiz) else $error("swap bit kept under hiz");
  a_off: assert property (p_off) else $error("stage not off on swap rise");
  a_off_len: assert property (p_off_len) else $error("stage off length");
  a_sp_rng: assert property (p_sp_rng) else $error("setpoint out of range");
  a_sp_step: assert property (p_sp_step) else $error("setpoint step");
  a_th_cap: assert property (p_th_cap) else $error("single cell cap");
  a_low_fall: assert property (p_low_fall) else $error("low flag held");
  a_dg: assert property (p_dg) else $error("low flag timing");
endmodule

// [dv/svo_host.sv]
// Host model: byte writes and reads on the register strobe port
`timescale 1ns/1ns
module svo_host (
  input wire logic clk,
  output svo_pkg::svo_req_s req,
  input wire logic [7:0] rdata
);
  initial req = '0;
  // Strobe lasts one clock; released address and data are inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~req.wdata};
    d = rdata;
  endtask
endmodule

// [dv/svo_regs_tb_top.sv]
// Testbench: register access sequences with expected values
`timescale 1ns/1ns
module svo_regs_tb_top;
  localparam int FRS = 20;
  localparam int DG = 5;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic mc = 1'b1;
  logic hiz = 1'b0;
  logic [5:0] th1 = 6'h0A;
  logic [15:0] rail = 16'hFFFF;
  svo_pkg::svo_req_s req;
  logic [7:0] rdata;
  logic [15:0] th_mv;
  logic [15:0] sp_mv;
  logic low;
  logic fsw;
  logic off;
  logic [7:0] v;
  int mismatches = 0;
  int cmp_count = 0;
  int n;
  // Last entry sets the two dead low bits; they must be stored as zero
  logic [31:0] tab [10] = '{32'h070A1588, 32'h07001588, 32'h074A1588, 32'h072F1588,
    32'h06E015C0, 32'h072E5DC0, 32'h07050BC0, 32'h06DC0BB8, 32'h06D80BB8, 32'h06DF0BB8};
  always #5 clk = ~clk;
  svo_host host (.clk(clk), .req(req), .rdata(rdata));
  svo_regs #(.FRS_OFF_CYCLES(FRS), .DEGLITCH_CYCLES(DG)) uut (.clk(clk), .rst_b(rst_b),
    .reg_req(req), .reg_rdata_q(rdata), .multi_cell(mc), .high_impedance_enable(hiz),
    .sys_rail_first_threshold(th1), .sys_rail_mv(rail), .sys_rail_second_threshold_mv_q(th_mv),
    .sys_rail_low_flag_q(low), .fast_swap_enable_q(fsw), .power_stage_off_q(off),
    .source_setpoint_mv_q(sp_mv));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk({8'h00, v}, {8'h00, e});
  endtask
  task automatic wr2(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    @(negedge clk);
  endtask
  // Bounded wait on the stage-off (sel 0) or low flag (sel 1) output
  task automatic wait_lvl(input logic sel, input logic lv);
    n = 0;
    while ((sel ? low : off) !== lv && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 100)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic do_reset(input logic m);
    @(negedge clk);
    rst_b = 1'b0;
    mc = m;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  initial
  begin
    do_reset(1'b1);
    rd_chk(svo_pkg::ADDR_PROT_LO, 8'h6C);
    rd_chk(svo_pkg::ADDR_VOUT_LO, 8'hC4);
    rd_chk(svo_pkg::ADDR_VOUT_HI, 8'h09);
    rd_chk(8'h55, 8'h00);
    chk(sp_mv, 16'h1388);
    chk(th_mv, 16'h170C);
    $display("test reset done");
    foreach (tab[i])
    begin
      wr2(tab[i][31:24], tab[i][23:16]);
      chk(sp_mv, tab[i][15:0]);
    end
    rd_chk(svo_pkg::ADDR_VOUT_LO, 8'hDC);
    rd_chk(svo_pkg::ADDR_VOUT_HI, 8'h05);
    $display("test setpoint done");
    wr2(svo_pkg::ADDR_PROT_LO, 8'hFC);
    chk(th_mv, 16'h251C);
    wr2(svo_pkg::ADDR_PROT_LO, 8'h02);
    chk(th_mv, 16'h1068);
    // Not sourcing power here, so the swap bit may change
    host.wr(svo_pkg::ADDR_PROT_LO, 8'h01);
    chk({14'h0000, fsw, off}, 16'h0003);
    wait_lvl(1'b0, 1'b0);
    chk(16'(n), 16'(FRS));
    rd_chk(svo_pkg::ADDR_PROT_LO, 8'h01);
    hiz = 1'b1;
    wr2(svo_pkg::ADDR_PROT_LO, 8'h01);
    chk({14'h0000, fsw, off}, 16'h0000);
    rd_chk(svo_pkg::ADDR_PROT_LO, 8'h00);
    $display("test fast swap done");
    do_reset(1'b0);
    rd_chk(svo_pkg::ADDR_PROT_LO, 8'h04);
    chk(th_mv, 16'h0CE4);
    wr2(svo_pkg::ADDR_PROT_LO, 8'hFC);
    chk(th_mv, 16'h0F3C);
    rail = 16'h0F3B;
    repeat (DG - 1) @(negedge clk);
    rail = 16'h0F3C;
    repeat (3) @(negedge clk);
    chk({15'h0000, low}, 16'h0000);
    rail = 16'h0F3B;
    wait_lvl(1'b1, 1'b1);
    // Flag is registered on the edge that takes the last of DG below samples
    chk(16'(n), 16'(DG));
    rail = 16'h0F3C;
    @(negedge clk);
    chk({15'h0000, low}, 16'h0000);
    $display("test undervoltage done");
    report_and_stop();
  end
endmodule
bind svo_regs svo_regs_monitor #(.FRS_OFF_CYCLES(FRS_OFF_CYCLES),
  .DEGLITCH_CYCLES(DEGLITCH_CYCLES)) mon (.clk(clk), .rst_b(rst_b), .reg_req(reg_req),
  .reg_rdata_q(reg_rdata_q), .multi_cell(multi_cell), .high_impedance_enable(high_impedance_enable),
  .sys_rail_first_threshold(sys_rail_first_threshold), .sys_rail_mv(sys_rail_mv),
  .sys_rail_second_threshold_mv_q(sys_rail_second_threshold_mv_q),
  .sys_rail_low_flag_q(sys_rail_low_flag_q), .fast_swap_enable_q(fast_swap_enable_q),
  .power_stage_off_q(power_stage_off_q), .source_setpoint_mv_q(source_setpoint_mv_q));
